// file: rtl/lsr_pkg.sv
// Constants for the self refresh, partial array refresh and register read block
package lsr_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  // Command/address encodings, rising edge
  localparam logic [2:0]  CMD_SREF        = 3'h4;   // ca[2:0] with ca2 high
  localparam logic [3:0]  CMD_MRW         = 4'h0;
  localparam logic [3:0]  CMD_MRR         = 4'h8;
  // Mode register addresses
  localparam logic [7:0]  ADDR_BANK_MASK  = 8'h10;
  localparam logic [7:0]  ADDR_SEG_MASK   = 8'h11;
  localparam logic [7:0]  ADDR_CAL_A      = 8'h20;
  localparam logic [7:0]  ADDR_CAL_B      = 8'h28;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [3:0]  CAL_A_PATTERN   = 4'h5;   // Beats 0..3 = 1,0,1,0 (bit n = beat n)
  localparam logic [3:0]  CAL_B_PATTERN   = 4'hc;   // Beats 0..3 = 0,0,1,1
  // Link timing in link clocks, burst length in beats
  localparam logic [3:0]  READ_LATENCY    = 4'h8;
  localparam logic [1:0]  REG_READ_PERIOD = 2'h2;
  localparam logic [2:0]  MRR_BEATS       = 3'h4;
  // Times in ns and derived clock counts
  localparam int unsigned MIN_SREF_NS     = 15;     // Longest wait before first refresh: round down
  localparam int unsigned SREF_EXIT_NS    = 140;    // Least time: round up
  localparam int unsigned REFRESH_INT_NS  = 7800;   // Longest interval: round down
  localparam int unsigned MIN_SREF_CYC_I  = (MIN_SREF_NS / CLK_PERIOD_NS) < 1 ? 1 : (MIN_SREF_NS / CLK_PERIOD_NS);
  localparam int unsigned SREF_EXIT_CYC_I = (SREF_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYC_I   = REFRESH_INT_NS / CLK_PERIOD_NS;
  localparam logic [11:0] MIN_SREF_CYC    = 12'(MIN_SREF_CYC_I);
  localparam logic [11:0] SREF_EXIT_CYC   = 12'(SREF_EXIT_CYC_I);
  localparam logic [11:0] REFRESH_CYC     = 12'(REFRESH_CYC_I);
  // Link sample vector layout
  localparam int unsigned SMP_WIDTH       = 13;
  localparam int unsigned SMP_CK          = 12;
  localparam int unsigned SMP_CKE         = 11;
  localparam int unsigned SMP_CS_N        = 10;

  typedef enum logic [1:0] {
    LSR_IDLE = 2'b00,
    LSR_SELF = 2'b01,
    LSR_EXIT = 2'b11
  } lsr_state_t;
endpackage : lsr_pkg

// file: rtl/lsr_link_sampler.sv
// Three-stage sampler for link pins with agreement filter
`timescale 1ns/100ps
module lsr_link_sampler #(
  parameter int unsigned WIDTH = 13
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] stable
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] stable_nxt;

  always_comb begin
    // A bit changes only once the second and third stages agree
    for (int i = 0; i < WIDTH; i++) begin
      stable_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stable_r[i];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      stable_r <= '0;
    end else begin
      s1_r     <= pinIn;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      stable_r <= stable_nxt;
    end
  end

  assign stable = stable_r;
endmodule : lsr_link_sampler

// file: rtl/lsr_self_refresh.sv
// Device side self refresh, partial array refresh masking and mode register access
`timescale 1ns/100ps
// How it works
// - Entry is clock_enable low, select low, ca0 ca1 low, ca2 high at rising edge.
// - While clock_enable stays low the device stays in self refresh, ignoring all else.
// - Device starts an all-bank refresh within min_self_refresh_time, internal clock gated.
// - Exit time starts at rising edge after clock_enable high; commands ignored meanwhile.
// - Eight-bit bank mask; masked banks get no self refresh.
// - Unmasked banks refresh only unmasked segments.
// - Eight segments per bank; one segment bit applies to all banks.
// - Bit 1 masks; region refreshed only when bank and segment bits are 0.
// - Register read is ca[3:0]=1000; address from falling 1:0 and rising 9:4.
// - Register value on data 7:0 in first beat after read_latency clocks.
// - Strobes toggle for the whole register read burst.
// - Register read bursts four beats, uninterrupted; two-clock period, no_operation only.
// - Register write is ca[3:0]=0000, allowed only with all banks idle.
// - Calibration registers return 1,0,1,0 and 0,0,1,1 on every data lane.
module lsr_self_refresh (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       linkClk,
  input  wire logic       cke,
  input  wire logic       csN,
  input  wire logic [9:0] commandAddressBus,
  output logic      [7:0] dqOut,
  output logic            dqOe,
  output logic            dqsOut,
  output logic            dqsNOut,
  output logic            dqsOe,
  output logic            selfRefreshActive,
  output logic            internalClkEn,
  output logic            refreshStrobe,
  output logic      [7:0] refreshBanks,
  output logic      [2:0] refreshSegment
);
  logic [lsr_pkg::SMP_WIDTH-1:0] smp;
  logic                          sCk;
  logic                          sCke;
  logic                          sCsN;
  logic [9:0]                    sCa;
  logic                          ckRise;
  logic                          ckFall;

  lsr_link_sampler #(
    .WIDTH (lsr_pkg::SMP_WIDTH)
  ) uSampler (
    .clk    (clk),
    .rstn   (rstn),
    .pinIn  ({linkClk, cke, csN, commandAddressBus}),
    .stable (smp)
  );

  assign sCk  = smp[lsr_pkg::SMP_CK];
  assign sCke = smp[lsr_pkg::SMP_CKE];
  assign sCsN = smp[lsr_pkg::SMP_CS_N];
  assign sCa  = smp[9:0];

  // Data for one beat of a register read
  function automatic logic [7:0] beatData(input logic [7:0] addr, input logic [1:0] beat,
                                          input logic [7:0] bankMask, input logic [7:0] segMask);
    logic [7:0] d;
    d = 8'h00;
    if (addr == lsr_pkg::ADDR_CAL_A) begin
      d = {8{lsr_pkg::CAL_A_PATTERN[beat]}};
    end else if (addr == lsr_pkg::ADDR_CAL_B) begin
      d = {8{lsr_pkg::CAL_B_PATTERN[beat]}};
    end else if (beat == 2'h0) begin
      if (addr == lsr_pkg::ADDR_BANK_MASK) begin
        d = bankMask;
      end else if (addr == lsr_pkg::ADDR_SEG_MASK) begin
        d = segMask;
      end
    end
    return d;
  endfunction : beatData

  lsr_pkg::lsr_state_t state_r;
  lsr_pkg::lsr_state_t state_nxt;
  logic        ckPrev_r;
  logic        ckPrev_nxt;
  logic        ckeAtRise_r;
  logic        ckeAtRise_nxt;
  logic [11:0] timer_r;
  logic [11:0] timer_nxt;
  logic [7:0]  bankMask_r;
  logic [7:0]  bankMask_nxt;
  logic [7:0]  segMask_r;
  logic [7:0]  segMask_nxt;
  logic        mrwPend_r;
  logic        mrwPend_nxt;
  logic        mrrPend_r;
  logic        mrrPend_nxt;
  logic [5:0]  addrHi_r;
  logic [5:0]  addrHi_nxt;
  logic [7:0]  rdAddr_r;
  logic [7:0]  rdAddr_nxt;
  logic [1:0]  holdCnt_r;
  logic [1:0]  holdCnt_nxt;
  logic [3:0]  latCnt_r;
  logic [3:0]  latCnt_nxt;
  logic        bursting_r;
  logic        bursting_nxt;
  logic [2:0]  beat_r;
  logic [2:0]  beat_nxt;
  logic [7:0]  dq_r;
  logic [7:0]  dq_nxt;
  logic        dqOe_r;
  logic        dqOe_nxt;
  logic        dqs_r;
  logic        dqs_nxt;
  logic        refStb_r;
  logic        refStb_nxt;
  logic [7:0]  refBanks_r;
  logic [7:0]  refBanks_nxt;
  logic [2:0]  seg_r;
  logic [2:0]  seg_nxt;
  logic        srAct_r;
  logic        srAct_nxt;
  logic        clkEn_r;
  logic        clkEn_nxt;

  assign ckRise = sCk & ~ckPrev_r;
  assign ckFall = ~sCk & ckPrev_r;

  always_comb begin
    state_nxt     = state_r;
    ckPrev_nxt    = sCk;
    ckeAtRise_nxt = ckeAtRise_r;
    timer_nxt     = timer_r;
    bankMask_nxt  = bankMask_r;
    segMask_nxt   = segMask_r;
    mrwPend_nxt   = mrwPend_r;
    mrrPend_nxt   = mrrPend_r;
    addrHi_nxt    = addrHi_r;
    rdAddr_nxt    = rdAddr_r;
    holdCnt_nxt   = holdCnt_r;
    latCnt_nxt    = latCnt_r;
    bursting_nxt  = bursting_r;
    beat_nxt      = beat_r;
    dq_nxt        = dq_r;
    dqOe_nxt      = dqOe_r;
    dqs_nxt       = dqs_r;
    refStb_nxt    = 1'b0;
    refBanks_nxt  = refBanks_r;
    seg_nxt       = seg_r;
    srAct_nxt     = srAct_r;
    clkEn_nxt     = clkEn_r;
    if (ckRise) begin
      ckeAtRise_nxt = sCke;
    end
    case (state_r)
      lsr_pkg::LSR_IDLE: begin
        srAct_nxt = 1'b0;
        clkEn_nxt = 1'b1;
        if (ckRise && holdCnt_r != 2'h0) begin
          holdCnt_nxt = holdCnt_r - 2'h1;
        end else if (ckRise && !sCsN && !bursting_r && latCnt_r == 4'h0) begin
          if (ckeAtRise_r && !sCke && sCa[2:0] == lsr_pkg::CMD_SREF) begin
            state_nxt = lsr_pkg::LSR_SELF;
            timer_nxt = lsr_pkg::MIN_SREF_CYC - 12'h001;
            srAct_nxt = 1'b1;
            clkEn_nxt = 1'b0;
            seg_nxt   = 3'h0;
          end else if (sCke && sCa[3:0] == lsr_pkg::CMD_MRW) begin
            mrwPend_nxt = 1'b1;
            addrHi_nxt  = sCa[9:4];
          end else if (sCke && sCa[3:0] == lsr_pkg::CMD_MRR) begin
            mrrPend_nxt = 1'b1;
            addrHi_nxt  = sCa[9:4];
            holdCnt_nxt = lsr_pkg::REG_READ_PERIOD - 2'h1;
            latCnt_nxt  = lsr_pkg::READ_LATENCY;
          end
        end
        if (ckFall && mrwPend_r) begin
          mrwPend_nxt = 1'b0;
          if ({addrHi_r, sCa[1:0]} == lsr_pkg::ADDR_BANK_MASK) begin
            bankMask_nxt = sCa[9:2];
          end else if ({addrHi_r, sCa[1:0]} == lsr_pkg::ADDR_SEG_MASK) begin
            segMask_nxt = sCa[9:2];
          end
        end
        if (ckFall && mrrPend_r) begin
          mrrPend_nxt = 1'b0;
          rdAddr_nxt  = {addrHi_r, sCa[1:0]};
        end
      end
      lsr_pkg::LSR_SELF: begin
        // All pins but clock enable are ignored here
        if (ckRise && sCke) begin
          state_nxt = lsr_pkg::LSR_EXIT;
          timer_nxt = lsr_pkg::SREF_EXIT_CYC;
          clkEn_nxt = 1'b1;
        end else if (timer_r == 12'h000) begin
          refStb_nxt   = 1'b1;
          refBanks_nxt = ~bankMask_r & {8{~segMask_r[seg_r]}};
          seg_nxt      = seg_r + 3'h1;
          timer_nxt    = lsr_pkg::REFRESH_CYC - 12'h001;
        end else begin
          timer_nxt = timer_r - 12'h001;
        end
      end
      lsr_pkg::LSR_EXIT: begin
        // Commands are not decoded until the exit time has run out
        if (timer_r <= 12'h001) begin
          state_nxt = lsr_pkg::LSR_IDLE;
          srAct_nxt = 1'b0;
        end else begin
          timer_nxt = timer_r - 12'h001;
        end
      end
      default: begin
        state_nxt = lsr_pkg::LSR_IDLE;
      end
    endcase
    if (!refStb_nxt) begin
      refBanks_nxt = 8'h00;
    end
    // Register read data burst, driven on both link clock edges
    if (ckRise && latCnt_r != 4'h0 && !bursting_r) begin
      latCnt_nxt = latCnt_r - 4'h1;
      if (latCnt_r == 4'h1) begin
        bursting_nxt = 1'b1;
        beat_nxt     = 3'h0;
        dqOe_nxt     = 1'b1;
        dqs_nxt      = 1'b1;
        dq_nxt       = beatData(rdAddr_r, 2'h0, bankMask_r, segMask_r);
      end
    end else if (bursting_r && (ckRise || ckFall)) begin
      if (beat_r == lsr_pkg::MRR_BEATS - 3'h1) begin
        bursting_nxt = 1'b0;
        dqOe_nxt     = 1'b0;
        dqs_nxt      = 1'b0;
        dq_nxt       = 8'h00;
      end else begin
        beat_nxt = beat_r + 3'h1;
        dqs_nxt  = ~dqs_r;
        dq_nxt   = beatData(rdAddr_r, beat_nxt[1:0], bankMask_r, segMask_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r     <= lsr_pkg::LSR_IDLE;
      ckPrev_r    <= 1'b0;
      ckeAtRise_r <= 1'b0;
      timer_r     <= 12'h000;
      bankMask_r  <= lsr_pkg::MASK_RESET;
      segMask_r   <= lsr_pkg::MASK_RESET;
      mrwPend_r   <= 1'b0;
      mrrPend_r   <= 1'b0;
      addrHi_r    <= 6'h00;
      rdAddr_r    <= 8'h00;
      holdCnt_r   <= 2'h0;
      latCnt_r    <= 4'h0;
      bursting_r  <= 1'b0;
      beat_r      <= 3'h0;
      dq_r        <= 8'h00;
      dqOe_r      <= 1'b0;
      dqs_r       <= 1'b0;
      refStb_r    <= 1'b0;
      refBanks_r  <= 8'h00;
      seg_r       <= 3'h0;
      srAct_r     <= 1'b0;
      clkEn_r     <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      ckPrev_r    <= ckPrev_nxt;
      ckeAtRise_r <= ckeAtRise_nxt;
      timer_r     <= timer_nxt;
      bankMask_r  <= bankMask_nxt;
      segMask_r   <= segMask_nxt;
      mrwPend_r   <= mrwPend_nxt;
      mrrPend_r   <= mrrPend_nxt;
      addrHi_r    <= addrHi_nxt;
      rdAddr_r    <= rdAddr_nxt;
      holdCnt_r   <= holdCnt_nxt;
      latCnt_r    <= latCnt_nxt;
      bursting_r  <= bursting_nxt;
      beat_r      <= beat_nxt;
      dq_r        <= dq_nxt;
      dqOe_r      <= dqOe_nxt;
      dqs_r       <= dqs_nxt;
      refStb_r    <= refStb_nxt;
      refBanks_r  <= refBanks_nxt;
      seg_r       <= seg_nxt;
      srAct_r     <= srAct_nxt;
      clkEn_r     <= clkEn_nxt;
    end
  end

  logic dqsN_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dqsN_r <= 1'b1;
    end else begin
      dqsN_r <= ~dqs_nxt;
    end
  end

  assign dqOut             = dq_r;
  assign dqOe              = dqOe_r;
  assign dqsOut            = dqs_r;
  assign dqsNOut           = dqsN_r;
  assign dqsOe             = dqOe_r;
  assign selfRefreshActive = srAct_r;
  assign internalClkEn     = clkEn_r;
  assign refreshStrobe     = refStb_r;
  assign refreshBanks      = refBanks_r;
  assign refreshSegment    = seg_r;
endmodule : lsr_self_refresh

// file: tb/lsr_self_refresh_assertions.sv
// Port checks for the self refresh and register read block
`timescale 1ns/100ps
module lsr_self_refresh_assertions (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       linkClk,
  input wire logic       cke,
  input wire logic       csN,
  input wire logic [9:0] commandAddressBus,
  input wire logic [7:0] dqOut,
  input wire logic       dqOe,
  input wire logic       dqsOut,
  input wire logic       dqsNOut,
  input wire logic       dqsOe,
  input wire logic       selfRefreshActive,
  input wire logic       internalClkEn,
  input wire logic       refreshStrobe,
  input wire logic [7:0] refreshBanks,
  input wire logic [2:0] refreshSegment
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_entry_low_cke: assert property ($rose(selfRefreshActive) |-> !cke && !internalClkEn)
    else $error("entry seen without low clock enable");
  a_first_refresh: assert property ($rose(selfRefreshActive) |-> ##[0:2] refreshStrobe)
    else $error("no refresh after entry");
  a_refresh_gated: assert property (refreshStrobe |-> selfRefreshActive && !internalClkEn)
    else $error("refresh outside self refresh");
  a_banks_pulse: assert property (!refreshStrobe |-> refreshBanks == 8'h00)
    else $error("banks shown without refresh");
  a_no_read_sr: assert property (selfRefreshActive |-> !dqOe)
    else $error("data driven in self refresh");
  a_exit_hold: assert property ($rose(internalClkEn) |-> cke && selfRefreshActive ##1
    selfRefreshActive[*4] ##[1:3] !selfRefreshActive)
    else $error("exit time wrong");
  a_burst_len: assert property ($rose(dqOe) |-> dqOe[*8] ##[6:10] !dqOe)
    else $error("read burst length wrong");
  a_first_strobe: assert property ($rose(dqOe) |-> dqsOut && dqsOe)
    else $error("first strobe wrong");
  a_strobe_pair: assert property (dqsNOut == !dqsOut && dqsOe == dqOe)
    else $error("strobe pair mismatch");
  a_strobe_toggle: assert property (dqOe |-> ##[1:5] (!dqOe || $changed(dqsOut)))
    else $error("strobe stopped in burst");
endmodule : lsr_self_refresh_assertions

// file: tb/lsr_ctrl_model.sv
// Memory controller model driving link clock, clock enable, select and command pins
`timescale 1ns/100ps
module lsr_ctrl_model (
  input  wire logic       clk,
  output logic            linkClk,
  output logic            cke,
  output logic            csN,
  output logic      [9:0] commandAddressBus
);
  initial begin
    linkClk = 1'b0;
    cke = 1'b1;
    csN = 1'b1;
    commandAddressBus = 10'h3ff;
  end
  // One link clock, pins changed mid-phase on clk falling edges
  task automatic link(input logic c, input logic s, input logic [9:0] r, input logic [9:0] f);
    repeat (2) @(negedge clk);
    cke = c;
    csN = s;
    commandAddressBus = r;
    repeat (2) @(negedge clk);
    linkClk = 1'b1;
    repeat (2) @(negedge clk);
    commandAddressBus = f;
    repeat (2) @(negedge clk);
    linkClk = 1'b0;
  endtask : link
  task automatic no_operation(input logic c);
    link(c, 1'b0, 10'h003, 10'h3fc);
  endtask : no_operation
  // Banks idle, clock enable high before entry, no_operation after
  task automatic sref_enter();
    no_operation(1'b1);
    link(1'b0, 1'b0, 10'h004, 10'h3fb);
    no_operation(1'b0);
  endtask : sref_enter
  // Two stable clocks, exit, no_operation during exit time, then all-bank refresh
  task automatic sref_exit();
    no_operation(1'b0);
    no_operation(1'b0);
    no_operation(1'b1);
    no_operation(1'b1);
    link(1'b1, 1'b0, 10'h00c, 10'h3f3);
    no_operation(1'b1);
  endtask : sref_exit
endmodule : lsr_ctrl_model

// file: tb/testbench.sv
// Self-checking bench for the self refresh and register read block
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       linkClk, cke, csN, dqOe, dqsOut, dqsNOut, dqsOe, selfRefreshActive, internalClkEn, refreshStrobe;
  logic [9:0] commandAddressBus;
  logic [7:0] dqOut, refreshBanks, bankM, segM;
  logic [2:0] refreshSegment;
  logic       segChk = 1'b0;
  int         nErrors = 0, nCompared = 0, nRef = 0, seg = 0, seed = 32'h212c;

  always #12.5 clk = ~clk;

  lsr_ctrl_model ctl_u (.clk(clk), .linkClk(linkClk), .cke(cke), .csN(csN), .commandAddressBus(commandAddressBus));
  lsr_self_refresh dut_u (.clk(clk), .rstn(rstn), .linkClk(linkClk), .cke(cke), .csN(csN),
    .commandAddressBus(commandAddressBus), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsNOut(dqsNOut),
    .dqsOe(dqsOe), .selfRefreshActive(selfRefreshActive), .internalClkEn(internalClkEn),
    .refreshStrobe(refreshStrobe), .refreshBanks(refreshBanks), .refreshSegment(refreshSegment));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    nCompared++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      nErrors++;
    end
  endtask : chk

  task automatic closeOut();
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : closeOut

  task cmd(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    ctl_u.link(1'b1, 1'b0, {a[7:2], op}, {d, a[1:0]});
  endtask : cmd

  // Register read; e holds the four expected beats, beat 0 lowest
  task automatic mode_register_read(input logic [7:0] a, input logic [31:0] e);
    int         i;
    logic [7:0] expQ[$];
    for (i = 0; i < 4; i++) begin
      expQ.push_back(e[8*i+:8]);
    end
    fork
      begin
        cmd(lsr_pkg::CMD_MRR, a, 8'h00);
        repeat (11) ctl_u.no_operation(1'b1);
      end
      begin
        i = 0;
        while (dqOe !== 1'b1 && i < 400) begin
          @(negedge clk);
          i++;
        end
        // Command rise 4 clocks in, read_latency link clocks of 8, then 5 clocks of pin lag
        chk("latency", 8'(lsr_pkg::READ_LATENCY) * 8'd8 + 8'd9, 8'(i));
        for (i = 0; i < 4; i++) begin
          chk("beat", expQ.pop_front(), dqOut);
          chk("strobe", {5'h0, 1'b1, 1'(i % 2), 1'(i % 2 == 0)}, {5'h0, dqsOe, dqsNOut, dqsOut});
          repeat (4) @(negedge clk);
        end
        chk("burst end", 8'h00, {7'h0, dqOe});
      end
    join
  endtask : mode_register_read

  // Every internal refresh against the mask model
  always @(negedge clk) begin
    if (segChk) chk("segment", 8'(seg), {5'h0, refreshSegment});
    segChk = (refreshStrobe === 1'b1);
    if (segChk) begin
      chk("banks", ~bankM & (segM[seg] ? 8'h00 : 8'hff), refreshBanks);
      seg = (seg + 1) % 8;
      nRef++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    closeOut();
  end

  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk("reset", 8'h0c, {4'h0, internalClkEn, dqsNOut, dqOe, selfRefreshActive});
    repeat (8) @(negedge clk);
    bankM = 8'($random(seed));
    segM = 8'($random(seed));
    cmd(lsr_pkg::CMD_MRW, lsr_pkg::ADDR_BANK_MASK, bankM);
    cmd(lsr_pkg::CMD_MRW, lsr_pkg::ADDR_SEG_MASK, segM);
    ctl_u.no_operation(1'b1);
    mode_register_read(lsr_pkg::ADDR_BANK_MASK, {24'h0, bankM});
    mode_register_read(lsr_pkg::ADDR_SEG_MASK, {24'h0, segM});
    mode_register_read(lsr_pkg::ADDR_CAL_A, 32'h00ff00ff);
    mode_register_read(lsr_pkg::ADDR_CAL_B, 32'hffff0000);
    mode_register_read(8'h33, 32'h0);
    $display("test register access done");
    ctl_u.sref_enter();
    chk("active", 8'h01, {6'h0, internalClkEn, selfRefreshActive});
    repeat (340) @(negedge clk);
    repeat (2) ctl_u.link(1'b0, 1'b0, {6'h04, lsr_pkg::CMD_MRR}, 10'h000);
    chk("ignored", 8'h01, {7'h0, selfRefreshActive & ~dqOe});
    chk("refreshes", 8'h02, 8'(nRef));
    ctl_u.sref_exit();
    chk("exited", 8'h02, {6'h0, internalClkEn, selfRefreshActive});
    mode_register_read(lsr_pkg::ADDR_BANK_MASK, {24'h0, bankM});
    mode_register_read(lsr_pkg::ADDR_SEG_MASK, {24'h0, segM});
    $display("test self refresh done");
    closeOut();
  end
endmodule : testbench

bind lsr_self_refresh lsr_self_refresh_assertions chk_u (.clk(clk), .rstn(rstn), .linkClk(linkClk), .cke(cke),
  .csN(csN), .commandAddressBus(commandAddressBus), .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut),
  .dqsNOut(dqsNOut), .dqsOe(dqsOe), .selfRefreshActive(selfRefreshActive), .internalClkEn(internalClkEn),
  .refreshStrobe(refreshStrobe), .refreshBanks(refreshBanks), .refreshSegment(refreshSegment));
